/* File: logic/aei_pkg.sv */
// Package of types and constants for the axis encoder interface.
package aei_pkg;

  // Position counter width.
  localparam int AEI_POS_W = 32;
  // Input synchroniser depth, three flip-flops.
  localparam int AEI_SYNC_W = 3;
  // Clock rate and the fastest legal count rate.
  localparam int AEI_CLK_HZ = 100_000_000;
  localparam int AEI_MAX_CNT_HZ = 15_000_000;
  localparam int AEI_MAX_CYC_HZ = 3_750_000;
  // Least clock cycles between two legal count edges (rounded down).
  localparam int AEI_MIN_EDGE_CYC = AEI_CLK_HZ / AEI_MAX_CNT_HZ;
  // Feedback modes.
  localparam logic AEI_MODE_QUAD = 1'h0;
  localparam logic AEI_MODE_PULSE = 1'h1;
  // Latch trigger sources.
  localparam logic AEI_TRIG_GEN = 1'h0;
  localparam logic AEI_TRIG_INDEX = 1'h1;
  // Reset values.
  localparam logic [AEI_POS_W-1:0] AEI_POS_RESET = 32'h0000_0000;
  localparam logic [AEI_SYNC_W-1:0] AEI_SYNC_RESET = 3'h0;

  // Raw encoder pins of one axis.
  typedef struct packed {
    logic quad_channel_a;
    logic quad_channel_b;
    logic index;
    logic aux_a;
    logic aux_b;
    logic gen_in;
  } aei_pins_t;

  // Whole state of the block.
  typedef struct packed {
    logic [AEI_SYNC_W-1:0] sync_a;
    logic [AEI_SYNC_W-1:0] sync_b;
    logic [AEI_SYNC_W-1:0] sync_idx;
    logic [AEI_SYNC_W-1:0] sync_gen;
    logic [AEI_SYNC_W-1:0] sync_aux_a;
    logic [AEI_SYNC_W-1:0] sync_aux_b;
    logic a;
    logic b;
    logic idx;
    logic gen;
    logic aux_a;
    logic aux_b;
    logic [AEI_POS_W-1:0] position;
    logic [AEI_POS_W-1:0] latch_pos;
    logic latch_valid;
    logic index_seen;
    logic compare_out;
  } aei_state_t;

endpackage

/* File: logic/aei_axis_encoder.sv */
// Single-axis encoder decoder with position latch and compare output.
// What this block does
// - Decode quadrature A and B into four counts per full cycle.
// - Count correctly up to 15 million counts per second.
// - Selectable pulse-and-direction mode: pulse counts in given direction.
// - Accept an index channel as once-per-revolution marker.
// - General input or index edge latches the axis position.
// - Compare output asserts when position reaches the compare position.
// - Auxiliary inputs readable as general inputs when unused.
`timescale 1ns/10ps
module aei_axis_encoder
  import aei_pkg::*;
#(
  parameter int POS_W = AEI_POS_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Encoder and general input pins.
  input wire aei_pins_t pins,
  // Configuration from the controller.
  input wire logic mode_pulse,
  input wire logic trig_index,
  input wire logic latch_arm,
  input wire logic [POS_W-1:0] compare_pos,
  // Results to the controller.
  output logic [POS_W-1:0] position,
  output logic [POS_W-1:0] latch_pos,
  output logic latch_valid,
  output logic index_seen,
  output logic compare_out,
  output logic aux_in_a,
  output logic aux_in_b
);

  aei_state_t st;
  aei_state_t next_st;
  logic new_a;
  logic new_b;
  logic new_idx;
  logic new_gen;
  logic step_up;
  logic step_dn;
  logic trig_edge;
  logic [POS_W-1:0] next_pos;

  // A change counts once the second and third flops agree.
  assign new_a = (st.sync_a[2] == st.sync_a[1]) ? st.sync_a[2] : st.a;
  assign new_b = (st.sync_b[2] == st.sync_b[1]) ? st.sync_b[2] : st.b;
  assign new_idx = (st.sync_idx[2] == st.sync_idx[1]) ? st.sync_idx[2]
                                                         : st.idx;
  assign new_gen = (st.sync_gen[2] == st.sync_gen[1]) ? st.sync_gen[2]
                                                         : st.gen;

  // Direction decode; in quadrature one accepted edge of A or B is one count, and a
  // count every cycle is far above the fastest legal edge rate.
  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    if (mode_pulse == AEI_MODE_PULSE) begin
      // Rising pulse edge moves in the direction on channel B.
      if (new_a && !st.a) begin
        step_up = !new_b;
        step_dn = new_b;
      end
    end else if ((new_a != st.a) ^ (new_b != st.b)) begin
      // One channel changed: four states per cycle give four counts.
      if (new_a != st.a) begin
        step_up = (new_a != new_b);
        step_dn = (new_a == new_b);
      end else begin
        step_up = (new_a == new_b);
        step_dn = (new_a != new_b);
      end
    end
  end

  // Latch trigger from the chosen source.
  assign trig_edge = (trig_index == AEI_TRIG_INDEX) ? (new_idx && !st.idx)
                                                    : (new_gen && !st.gen);

  // Next position.
  assign next_pos = step_up ? st.position + 1'b1
                  : step_dn ? st.position - 1'b1 : st.position;

  // Next state of the whole block.
  always_comb begin
    next_st = st;
    next_st.sync_a = {st.sync_a[1:0], pins.quad_channel_a};
    next_st.sync_b = {st.sync_b[1:0], pins.quad_channel_b};
    next_st.sync_idx = {st.sync_idx[1:0], pins.index};
    next_st.sync_gen = {st.sync_gen[1:0], pins.gen_in};
    next_st.sync_aux_a = {st.sync_aux_a[1:0], pins.aux_a};
    next_st.sync_aux_b = {st.sync_aux_b[1:0], pins.aux_b};
    next_st.a = new_a;
    next_st.b = new_b;
    next_st.idx = new_idx;
    next_st.gen = new_gen;
    // Auxiliary inputs are plain filtered general inputs.
    if (st.sync_aux_a[2] == st.sync_aux_a[1]) begin
      next_st.aux_a = st.sync_aux_a[2];
    end
    if (st.sync_aux_b[2] == st.sync_aux_b[1]) begin
      next_st.aux_b = st.sync_aux_b[2];
    end
    next_st.position = next_pos;
    // Index rising edge marks a revolution.
    if (new_idx && !st.idx) begin
      next_st.index_seen = 1'b1;
    end
    // An armed latch captures the position on the trigger edge.
    if (latch_arm && !st.latch_valid && trig_edge) begin
      next_st.latch_pos = st.position;
      next_st.latch_valid = 1'b1;
    end else if (!latch_arm) begin
      next_st.latch_valid = 1'b0;
    end
    // Compare output stands while the position equals the target.
    next_st.compare_out = (next_pos == compare_pos);
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops.
  assign position = st.position;
  assign latch_pos = st.latch_pos;
  assign latch_valid = st.latch_valid;
  assign index_seen = st.index_seen;
  assign compare_out = st.compare_out;
  assign aux_in_a = st.aux_a;
  assign aux_in_b = st.aux_b;

  // Assertions share the block clock and stay quiet during reset.
  default clocking chk_clk @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Up count in quadrature moves position by exactly one.
  quad_up_count_a: assert property (
    (mode_pulse == AEI_MODE_QUAD && step_up) |=>
      position == $past(position) + 1'b1)
    else $error("Quadrature up step did not add one.");

  // Down count in quadrature moves position back by exactly one.
  quad_dn_count_a: assert property (
    (mode_pulse == AEI_MODE_QUAD && step_dn) |=>
      position == $past(position) - 1'b1)
    else $error("Quadrature down step did not take one.");

  // Both channels changing in quadrature leaves position alone.
  quad_both_ignored_a: assert property (
    (mode_pulse == AEI_MODE_QUAD && new_a != st.a && new_b != st.b) |=>
      $stable(position))
    else $error("Simultaneous channel change moved position.");

  // Every single-channel edge is one count, so a cycle gives four.
  quad_edge_count_a: assert property (
    (mode_pulse == AEI_MODE_QUAD && ((new_a != st.a) != (new_b != st.b)))
      |=> (position == $past(position) + 1'b1) ||
          (position == $past(position) - 1'b1))
    else $error("Quadrature edge did not move position by one.");

  // Pulse mode counts down when direction is high.
  pulse_dir_a: assert property (
    (mode_pulse == AEI_MODE_PULSE && new_a && !st.a && new_b) |=>
      position == $past(position) - 1'b1)
    else $error("Pulse with direction high did not count down.");

  // Pulse mode counts up when direction is low.
  pulse_up_a: assert property (
    (mode_pulse == AEI_MODE_PULSE && new_a && !st.a && !new_b) |=>
      position == $past(position) + 1'b1)
    else $error("Pulse with direction low did not count up.");

  // Latch captures the position held at the trigger edge.
  latch_capture_a: assert property (
    (latch_arm && !latch_valid && trig_edge) |=>
      latch_valid && latch_pos == $past(position))
    else $error("Latch missed the trigger position.");

  // A captured position is kept while the latch stays armed.
  latch_hold_a: assert property (
    (latch_arm && latch_valid) |=> $stable(latch_pos))
    else $error("Latched position changed while held.");

  // Dropping the arm clears the latch on the next edge.
  latch_clear_a: assert property (
    !latch_arm |=> !latch_valid)
    else $error("Latch stayed valid after disarm.");

  // Compare follows equality of position and target.
  compare_match_a: assert property (
    $stable(compare_pos) |-> compare_out == (position == compare_pos))
    else $error("Compare output disagrees with position.");

  // Index edge sets the revolution marker within one cycle.
  index_mark_a: assert property (
    (new_idx && !st.idx) |=> index_seen)
    else $error("Index edge not recorded.");

  // The revolution marker stays set until reset.
  index_sticky_a: assert property (
    index_seen |=> index_seen)
    else $error("Index marker dropped without reset.");

  // Steady auxiliary pin shows on its output after four cycles.
  aux_follow_a: assert property (
    (pins.aux_a == 1'b1) [*4] |=> aux_in_a)
    else $error("Auxiliary input did not follow its pin.");

  // The second auxiliary input follows a steady low level.
  aux_b_low_a: assert property (
    (pins.aux_b == 1'b0) [*4] |=> !aux_in_b)
    else $error("Second auxiliary input did not follow its pin.");

  // Main scenarios that the bench should reach.
  cov_up_c: cover property (step_up);
  cov_dn_c: cover property (step_dn);
  cov_both_c: cover property (
    mode_pulse == AEI_MODE_QUAD && new_a != st.a && new_b != st.b);
  cov_latch_c: cover property (latch_arm && trig_edge);
  cov_cmp_c: cover property (compare_out);

endmodule // aei_axis_encoder

/* File: verif/aei_encoder_model.sv */
// Behavioural encoder that drives the pins of one axis.
`timescale 1ns/10ps
module aei_encoder_model
  import aei_pkg::*;
(
  // Clock used only to space the edges.
  input wire logic clk,
  // Encoder and general pins toward the axis.
  output aei_pins_t pins
);
  logic [1:0] ph = 2'h0;
  initial pins = '0;
  // One cycle above the rounded-down minimum keeps the edge rate legal.
  task automatic hold();
    repeat (AEI_MIN_EDGE_CYC + 1) @(posedge clk);
    #1;
  endtask
  // One quadrature step; A leads B when counting up.
  task automatic quad(input logic up);
    ph = up ? ph + 2'h1 : ph - 2'h1;
    pins.quad_channel_a = ph[1] ^ ph[0];
    pins.quad_channel_b = ph[1];
    hold();
  endtask
  // Both channels flip at once, which the axis must ignore.
  task automatic both();
    ph = ph + 2'h2;
    pins.quad_channel_a = ph[1] ^ ph[0];
    pins.quad_channel_b = ph[1];
    hold();
  endtask
  // One pulse with direction high for down.
  task automatic pulse(input logic up);
    pins.quad_channel_b = ~up;
    pins.quad_channel_a = 1'b1;
    hold();
    pins.quad_channel_a = 1'b0;
    hold();
    ph = {2{pins.quad_channel_b}};
  endtask
  // Sets both auxiliary inputs and lets them settle.
  task automatic aux(input logic [1:0] v);
    pins.aux_a = v[1];
    pins.aux_b = v[0];
    hold();
  endtask
  // Pulses the index line or the general input.
  task automatic trig(input logic idx);
    if (idx) pins.index = 1'b1; else pins.gen_in = 1'b1;
    hold();
    pins.index = 1'b0;
    pins.gen_in = 1'b0;
    hold();
  endtask
endmodule // aei_encoder_model

/* File: verif/aei_axis_encoder_bench.sv */
// Self-checking bench for the single-axis encoder block.
`timescale 1ns/10ps
module aei_axis_encoder_bench;
  import aei_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, mode_pulse = 1'b0;
  logic trig_index = 1'b0, latch_arm = 1'b0;
  logic [AEI_POS_W-1:0] compare_pos = '1, exp_pos = '0, last = '0;
  logic [AEI_POS_W-1:0] position, latch_pos, want, notes[$];
  logic [1:0] aux_val;
  logic latch_valid, index_seen, compare_out, aux_in_a, aux_in_b;
  aei_pins_t pins;
  int fail_count = 0, checks_done = 0, cycles = 0;
  aei_encoder_model enc (.clk(clk), .pins(pins));
  aei_axis_encoder dut (.clk(clk), .reset_n(reset_n), .pins(pins),
    .mode_pulse(mode_pulse), .trig_index(trig_index),
    .latch_arm(latch_arm), .compare_pos(compare_pos),
    .position(position), .latch_pos(latch_pos),
    .latch_valid(latch_valid), .index_seen(index_seen),
    .compare_out(compare_out), .aux_in_a(aux_in_a), .aux_in_b(aux_in_b));
  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end
  // Compares one result and counts it.
  task automatic check(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Notes the next count, then moves the encoder one step.
  task automatic move(input logic up);
    exp_pos = up ? exp_pos + 1 : exp_pos - 1;
    notes.push_back(exp_pos);
    if (mode_pulse) enc.pulse(up); else enc.quad(up);
  endtask
  // Each change of position takes the oldest note; also cuts a hang.
  always @(negedge clk) begin
    cycles++;
    if (reset_n && position !== last) begin
      want = notes.size() ? notes.pop_front() : ~position;
      check("position", want, position);
      last = position;
    end
    if (cycles > 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // Main sequence of tests.
  initial begin
    void'($urandom(96));
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    @(posedge clk);
    #1;
    repeat (6) move(1'b1);
    repeat (3) move(1'b0);
    enc.both();
    repeat (3) move(1'b1);
    $display("quadrature test done");
    mode_pulse = 1'b1;
    repeat (8) move(1'($urandom_range(1, 0)));
    mode_pulse = 1'b0;
    $display("pulse test done");
    compare_pos = exp_pos + 1;
    @(posedge clk);
    #1;
    check("compare idle", 0, compare_out);
    move(1'b1);
    check("compare hit", 1, compare_out);
    move(1'b1);
    check("compare left", 0, compare_out);
    $display("compare test done");
    latch_arm = 1'b1;
    enc.trig(1'b0);
    check("latch valid", 1, latch_valid);
    check("latch gen", exp_pos, latch_pos);
    move(1'b0);
    enc.trig(1'b0);
    check("latch held", exp_pos + 1, latch_pos);
    latch_arm = 1'b0;
    trig_index = 1'b1;
    repeat (2) @(posedge clk);
    #1 latch_arm = 1'b1;
    check("latch cleared", 0, latch_valid);
    check("index idle", 0, index_seen);
    enc.trig(1'b1);
    check("latch index", exp_pos, latch_pos);
    check("index seen", 1, index_seen);
    $display("latch test done");
    aux_val = 2'($urandom_range(3, 0));
    repeat (2) begin
      enc.aux(aux_val);
      check("aux", aux_val, {aux_in_a, aux_in_b});
      aux_val = ~aux_val;
    end
    $display("aux test done");
    check("position end", exp_pos, position);
    check("notes left", 0, notes.size());
    tally_and_finish();
  end
endmodule // aei_axis_encoder_bench
